// ---- core/pwr_de_map.vh ----
// Register offsets, field positions, reset values and timing-code bytes
// Assumes an 8-bit register space reached over the two-wire control port
`ifndef PWR_EN_MAP_VH
`define PWR_EN_MAP_VH

`define A_PDN     8'h26
`define A_OPT     8'h27
`define A_VDLY    8'h28
`define A_HDL     8'h29
`define A_LWH     8'h2a
`define A_LWL     8'h2b
`define A_SHH     8'h2c
`define A_SHL     8'h2d

`define B_PD      0
`define F_FN      2:1
`define B_POL     3
`define B_AUTO    7
`define B_A0      6
`define B_MCLK    5
`define B_EMB     4
`define B_FRC     3
`define F_IOF     2:0
`define F_VD      7:2
`define F_HDH     1:0

`define R_PDN     4'h8
`define R_OPT     8'h80
`define R_VD      6'h00
`define R_HDH     2'h1
`define R_HDL     8'h04
`define R_LWH     4'h5
`define R_LWL     8'h00
`define R_SHH     4'h2
`define R_SHL     8'hd0

`define SYNC_HI   8'hff
`define SYNC_LO   8'h00
`define CODE_OFF  3'h4

`endif

// ---- core/serial_ctl_slave.v ----
// Two-wire serial control port slave: sub-address, auto-increment, reads
// Assumes scl/sda come from pins asynchronous to mclk_i, far slower than it
`timescale 1ns/10ps
module serial_ctl_slave #(
  parameter [6:0] DEV_ADDR = 7'h4c
) (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_oe_o,
  output reg        wr_o,
  output reg  [7:0] addr_o,
  output reg  [7:0] wdata_o,
  input  wire [7:0] rdata_i
);
  localparam S_IDLE = 4'h0;
  localparam S_ADDR = 4'h1;
  localparam S_ACKA = 4'h2;
  localparam S_SUB  = 4'h3;
  localparam S_ACKS = 4'h4;
  localparam S_WDAT = 4'h5;
  localparam S_ACKW = 4'h6;
  localparam S_RDAT = 4'h7;
  localparam S_RACK = 4'h8;

  reg [1:0] scl_s_r;
  reg [1:0] sda_s_r;
  reg       scl_d_r;
  reg       sda_d_r;
  reg [3:0] st_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r;
  reg [7:0] tx_r;
  reg       rnw_r;
  reg       mack_r;

  wire scl_rise = scl_s_r[1] & ~scl_d_r;
  wire scl_fall = ~scl_s_r[1] & scl_d_r;
  wire start    = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  wire stop     = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_s_r  <= 2'h3;
      sda_s_r  <= 2'h3;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      st_r     <= S_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      rnw_r    <= 1'b0;
      mack_r   <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_o     <= 1'b0;
      addr_o   <= 8'h00;
      wdata_o  <= 8'h00;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      wr_o    <= 1'b0;
      if (start)
      begin
        st_r     <= S_ADDR;
        cnt_r    <= 4'h0;
        sda_oe_o <= 1'b0;
      end
      else if (stop)
      begin
        st_r     <= S_IDLE;
        sda_oe_o <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (st_r)
          S_ADDR, S_SUB, S_WDAT:
          begin
            sh_r  <= {sh_r[6:0], sda_s_r[1]};
            cnt_r <= cnt_r + 4'h1;
          end
          S_RACK:  mack_r <= ~sda_s_r[1];
          default: mack_r <= mack_r;
        endcase
      end
      else if (scl_fall)
      begin
        case (st_r)
          S_ADDR:
            if (cnt_r == 4'h8)
            begin
              if (sh_r[7:1] == DEV_ADDR)
              begin
                sda_oe_o <= 1'b1;
                rnw_r    <= sh_r[0];
                st_r     <= S_ACKA;
              end
              else
                st_r <= S_IDLE;
            end
          S_SUB:
            if (cnt_r == 4'h8)
            begin
              sda_oe_o <= 1'b1;
              addr_o   <= sh_r;
              st_r     <= S_ACKS;
            end
          S_WDAT:
            if (cnt_r == 4'h8)
            begin
              sda_oe_o <= 1'b1;
              wdata_o  <= sh_r;
              wr_o     <= 1'b1;
              st_r     <= S_ACKW;
            end
          S_ACKA:
            if (rnw_r)
            begin
              tx_r     <= rdata_i;
              sda_oe_o <= ~rdata_i[7];
              cnt_r    <= 4'h1;
              st_r     <= S_RDAT;
            end
            else
            begin
              sda_oe_o <= 1'b0;
              cnt_r    <= 4'h0;
              st_r     <= S_SUB;
            end
          S_ACKS, S_ACKW:
          begin
            sda_oe_o <= 1'b0;
            cnt_r    <= 4'h0;
            st_r     <= S_WDAT;
            if (st_r == S_ACKW)
              addr_o <= addr_o + 8'h01;
          end
          S_RDAT:
            if (cnt_r == 4'h8)
            begin
              sda_oe_o <= 1'b0;
              addr_o   <= addr_o + 8'h01;
              st_r     <= S_RACK;
            end
            else
            begin
              sda_oe_o <= ~tx_r[6];
              tx_r     <= {tx_r[6:0], 1'b0};
              cnt_r    <= cnt_r + 4'h1;
            end
          S_RACK:
            if (mack_r)
            begin
              tx_r     <= rdata_i;
              sda_oe_o <= ~rdata_i[7];
              cnt_r    <= 4'h1;
              st_r     <= S_RDAT;
            end
            else
              st_r <= S_IDLE;
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// ---- core/power_and_de_timing_controls.v ----
// Power-down, option and data-enable generator registers with their logic
// Assumes video pins and power pin are asynchronous; syncs are active high
`timescale 1ns/10ps
`include "pwr_de_map.vh"

module power_and_de_timing_controls #(
  parameter [6:0] DEV_ADDR = 7'h4c
) (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output wire       sda_oe_o,
  input  wire       power_down_pin_i,
  input  wire       link_idle_i,
  input  wire       hsync_i,
  input  wire       vsync_i,
  input  wire       ext_active_video_i,
  input  wire [7:0] pix_data_i,
  output reg        power_down_o,
  output reg        sync_on_green_tristate_o,
  output reg        out_tristate_o,
  output reg        low_power_o,
  output reg        protect_port_addr_bit_o,
  output reg        ext_audio_clk_sel_o,
  output reg        active_video_flag_o,
  output reg  [7:0] pix_data_o
);
  reg  [3:0]  pdn_r;
  reg  [7:0]  opt_r;
  reg  [7:0]  vdly_r;
  reg  [7:0]  hdl_r;
  reg  [3:0]  lwh_r;
  reg  [7:0]  lwl_r;
  reg  [3:0]  shh_r;
  reg  [7:0]  shl_r;
  reg  [7:0]  rdata;
  reg  [4:0]  s1_r;
  reg  [4:0]  s2_r;
  reg  [7:0]  d1_r;
  reg  [7:0]  d2_r;
  reg         hs_q_r;
  reg         vs_q_r;
  reg  [11:0] hcnt_r;
  reg  [11:0] vline_r;
  reg         field_r;
  reg  [3:0]  en_p_r;
  reg  [31:0] dat_p_r;
  reg  [2:0]  cidx_r;
  reg         eav_r;
  wire        wr;
  wire [7:0]  waddr;
  wire [7:0]  wdata;

  serial_ctl_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_oe_o (sda_oe_o),
    .wr_o     (wr),
    .addr_o   (waddr),
    .wdata_o  (wdata),
    .rdata_i  (rdata)
  );

  function [7:0] code_xy;
    input f;
    input v;
    input h;
    begin
      code_xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    end
  endfunction

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pdn_r  <= `R_PDN;
      opt_r  <= `R_OPT;
      vdly_r <= {`R_VD, `R_HDH};
      hdl_r  <= `R_HDL;
      lwh_r  <= `R_LWH;
      lwl_r  <= `R_LWL;
      shh_r  <= `R_SHH;
      shl_r  <= `R_SHL;
    end
    else if (wr)
    begin
      case (waddr)
        `A_PDN:  pdn_r  <= wdata[3:0];
        `A_OPT:  opt_r  <= wdata;
        `A_VDLY: vdly_r <= wdata;
        `A_HDL:  hdl_r  <= wdata;
        `A_LWH:  lwh_r  <= wdata[3:0];
        `A_LWL:  lwl_r  <= wdata;
        `A_SHH:  shh_r  <= wdata[3:0];
        `A_SHL:  shl_r  <= wdata;
        default: pdn_r  <= pdn_r;
      endcase
    end
  end

  always @*
  begin
    case (waddr)
      `A_PDN:  rdata = {4'h0, pdn_r};
      `A_OPT:  rdata = opt_r;
      `A_VDLY: rdata = vdly_r;
      `A_HDL:  rdata = hdl_r;
      `A_LWH:  rdata = {4'h0, lwh_r};
      `A_LWL:  rdata = lwl_r;
      `A_SHH:  rdata = {4'h0, shh_r};
      `A_SHL:  rdata = shl_r;
      default: rdata = 8'h00;
    endcase
  end

  wire        pin_s   = s2_r[0];
  wire        idle_s  = s2_r[1];
  wire        hs_s    = s2_r[2];
  wire        vs_s    = s2_r[3];
  wire        xde_s   = s2_r[4];
  wire        hs_rise = hs_s & ~hs_q_r;
  wire        vs_rise = vs_s & ~vs_q_r;
  wire        pin_act = pdn_r[`B_POL] ? pin_s : ~pin_s;
  wire        pd_req  = pdn_r[`B_PD] | pin_act;
  wire [1:0]  fn      = pdn_r[`F_FN];

  wire [12:0] vstart  = {7'h00, vdly_r[`F_VD]}
                      + (field_r ? {10'h000, opt_r[`F_IOF]} : 13'h0000);
  wire [12:0] vend    = vstart + {1'b0, shh_r, shl_r};
  wire [12:0] hstart  = {3'h0, vdly_r[`F_HDH], hdl_r};
  wire [12:0] hend    = hstart + {1'b0, lwh_r, lwl_r};
  wire        vact    = ({1'b0, vline_r} >= vstart) & ({1'b0, vline_r} < vend);
  wire        gen_en  = vact & ({1'b0, hcnt_r} >= hstart) & ({1'b0, hcnt_r} < hend);
  wire        en_sel  = opt_r[`B_FRC] ? gen_en : xde_s;

  wire        sav_go  = en_sel & ~en_p_r[0];
  wire        eav_go  = active_video_flag_o & ~en_p_r[3];
  wire        c_start = sav_go | eav_go;
  wire [2:0]  c_idx   = c_start ? 3'h0 : cidx_r;
  wire        c_h     = c_start ? ~sav_go : eav_r;
  wire        c_on    = opt_r[`B_EMB] & (c_idx != `CODE_OFF);
  wire [7:0]  c_xy    = code_xy(field_r, ~vact, c_h);

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_r    <= 5'h00;
      s2_r    <= 5'h00;
      d1_r    <= 8'h00;
      d2_r    <= 8'h00;
      hs_q_r  <= 1'b0;
      vs_q_r  <= 1'b0;
      hcnt_r  <= 12'h000;
      vline_r <= 12'h000;
      field_r <= 1'b0;
      en_p_r  <= 4'h0;
      dat_p_r <= 32'h0000_0000;
      cidx_r  <= `CODE_OFF;
      eav_r   <= 1'b0;
      sda_o   <= 1'b0;
      power_down_o            <= 1'b0;
      sync_on_green_tristate_o <= 1'b0;
      out_tristate_o          <= 1'b0;
      low_power_o             <= 1'b0;
      protect_port_addr_bit_o <= 1'b0;
      ext_audio_clk_sel_o     <= 1'b0;
      active_video_flag_o     <= 1'b0;
      pix_data_o              <= 8'h00;
    end
    else
    begin
      s1_r   <= {ext_active_video_i, vsync_i, hsync_i, link_idle_i, power_down_pin_i};
      s2_r   <= s1_r;
      d1_r   <= pix_data_i;
      d2_r   <= d1_r;
      hs_q_r <= hs_s;
      vs_q_r <= vs_s;
      sda_o  <= 1'b0;
      power_down_o   <= pd_req & ~fn[1];
      sync_on_green_tristate_o <= pd_req & fn[0];
      out_tristate_o <= pd_req & fn[1];
      low_power_o <= opt_r[`B_AUTO] & idle_s;
      protect_port_addr_bit_o <= opt_r[`B_A0];
      ext_audio_clk_sel_o <= opt_r[`B_MCLK];
      if (hs_rise)
        hcnt_r <= 12'h000;
      else if (hcnt_r != 12'hfff)
        hcnt_r <= hcnt_r + 12'h001;
      if (vs_rise)
      begin
        vline_r <= 12'h000;
        field_r <= ~field_r;
      end
      else if (hs_rise && vline_r != 12'hfff)
        vline_r <= vline_r + 12'h001;
      en_p_r  <= {en_p_r[2:0], en_sel};
      dat_p_r <= {dat_p_r[23:0], d2_r};
      active_video_flag_o <= en_p_r[3];
      eav_r  <= c_h;
      cidx_r <= (c_idx == `CODE_OFF) ? `CODE_OFF : c_idx + 3'h1;
      if (c_on)
      begin
        case (c_idx)
          3'h0:    pix_data_o <= `SYNC_HI;
          3'h3:    pix_data_o <= c_xy;
          default: pix_data_o <= `SYNC_LO;
        endcase
      end
      else
        pix_data_o <= dat_p_r[31:24];
    end
  end
endmodule

// ---- dv/pdt_asserts.sv ----
// Checker for the power and enable register block, bound to its ports
// Assumes mclk_i is the only clock and rst_i an active-high async reset
`timescale 1ns/10ps
module pdt_asserts (
  input wire       mclk_i,
  input wire       rst_i,
  input wire       scl_i,
  input wire       link_idle_i,
  input wire [7:0] pix_data_i,
  input wire       sda_oe_o,
  input wire       power_down_o,
  input wire       sync_on_green_tristate_o,
  input wire       out_tristate_o,
  input wire       low_power_o,
  input wire       protect_port_addr_bit_o,
  input wire       ext_audio_clk_sel_o,
  input wire       active_video_flag_o,
  input wire [7:0] pix_data_o
);
  logic [12:0] run_r;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // Length of the current enable run
  always @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      run_r <= 13'h0;
    else
      run_r <= active_video_flag_o ? run_r + 13'h1 : 13'h0;

  property p_ack_scl_low;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_ack_scl_low: assert property (p_ack_scl_low) else $error("sda moved with scl high");
  property p_a0_write;
    $changed(protect_port_addr_bit_o) |-> !scl_i;
  endproperty
  a_a0_write: assert property (p_a0_write) else $error("address bit moved");
  property p_mclk_write;
    $changed(ext_audio_clk_sel_o) |-> !scl_i;
  endproperty
  a_mclk_write: assert property (p_mclk_write) else $error("clock select moved");
  property p_idle_exit;
    $fell(link_idle_i) |-> ##[1:5] !low_power_o;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("low power kept");
  property p_green_pair;
    sync_on_green_tristate_o |-> power_down_o || out_tristate_o;
  endproperty
  a_green_pair: assert property (p_green_pair) else $error("lone green tristate");
  property p_pd_excl;
    !(power_down_o && out_tristate_o);
  endproperty
  a_pd_excl: assert property (p_pd_excl) else $error("two power modes");
  property p_data_align;
    active_video_flag_o |-> pix_data_o == $past(pix_data_i, 7);
  endproperty
  a_data_align: assert property (p_data_align) else $error("pixel misaligned");
  property p_run_max;
    run_r < 13'h1000;
  endproperty
  a_run_max: assert property (p_run_max) else $error("enable run too long");
  c_video: cover property ($rose(active_video_flag_o));
  c_green: cover property (sync_on_green_tristate_o && out_tristate_o);
  c_lowp: cover property (low_power_o);
endmodule

bind power_and_de_timing_controls pdt_asserts pdt_asserts_i (.*);

// ---- dv/host_model.sv ----
// Host of the two-wire control port: single writes, burst reads
// Assumes the bench resolves sda as open drain with a pull-up
`timescale 1ns/10ps
module host_model (
  output logic scl_o,
  output logic sda_oe_o,
  input  wire  sda_i
);
  localparam int T = 80;
  localparam logic [6:0] DEV = 7'h4c;
  logic [7:0] rb [16];

  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Data moves only mid low phase, away from scl edges
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      #(T / 2) sda_oe_o = ~d[i];
      #(T / 2) scl_o = 1'b1;
      q[i] = sda_i;
      #T scl_o = 1'b0;
    end
  endtask
  task automatic start();
    #(T / 2) sda_oe_o = 1'b0;
    #(T / 2) scl_o = 1'b1;
    #T sda_oe_o = 1'b1;
    #T scl_o = 1'b0;
  endtask
  task automatic stop();
    #(T / 2) sda_oe_o = 1'b1;
    #(T / 2) scl_o = 1'b1;
    #T sda_oe_o = 1'b0;
    #T;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] v,
    output logic ok);
    logic [8:0] q0, q1, q2;
    start();
    xfer({dev, 2'b01}, q0);
    xfer({a, 1'b1}, q1);
    xfer({v, 1'b1}, q2);
    stop();
    ok = !q0[0] && !q1[0] && !q2[0];
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic [8:0] q;
    start();
    xfer({DEV, 2'b01}, q);
    xfer({a, 1'b1}, q);
    start();
    xfer({DEV, 2'b11}, q);
    for (int k = 0; k < n; k++)
    begin
      xfer({8'hff, k == n - 1}, q);
      rb[k] = q[8:1];
    end
    stop();
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Bench: reset values, option bits, power modes, generated enable, codes
// Assumes the host model is entered on falling mclk edges only
`timescale 1ns/10ps
module tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pin, idle, hs, vs, ext, emb, fld, ok, av_d;
  logic [7:0]  pix_i, d;
  logic [31:0] hist;
  wire         scl, hoe, soe, sdo, pd, sgt, otri, lp, a0, mck, av;
  wire  [7:0]  pix_o;
  wire         sda = !(hoe || soe);
  int          err_count = 0;
  int          samples_checked = 0;
  logic [7:0]  rst_tab [9] = '{8'h08, 8'h80, 8'h01, 8'h04, 8'h05, 8'h00, 8'h02, 8'hd0, 8'h00};
  logic [7:0]  v_tab [6] = '{8'h08, 8'h03, 8'h00, 8'h06, 8'h00, 8'h02};
  logic [7:0]  opt_tab [3] = '{8'h00, 8'h08, 8'h19};

  always #4 mclk_i = ~mclk_i;
  power_and_de_timing_controls power_and_de_timing_controls_i (.mclk_i(mclk_i),
    .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(soe),
    .power_down_pin_i(pin), .link_idle_i(idle), .hsync_i(hs), .vsync_i(vs),
    .ext_active_video_i(ext), .pix_data_i(pix_i), .power_down_o(pd),
    .sync_on_green_tristate_o(sgt), .out_tristate_o(otri), .low_power_o(lp),
    .protect_port_addr_bit_o(a0), .ext_audio_clk_sel_o(mck),
    .active_video_flag_o(av), .pix_data_o(pix_o));
  host_model host_model_i (.scl_o(scl), .sda_oe_o(hoe), .sda_i(sda));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] pwr(input logic [1:0] fn, input logic act);
    pwr = !act ? 8'h00 : fn == 2'b00 ? 8'h04 : fn == 2'b01 ? 8'h06 : fn == 2'b10 ? 8'h01 : 8'h03;
  endfunction
  function automatic logic [7:0] xy(input logic f, input logic v, input logic h);
    xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction
  task automatic line(input int exp);
    int n;
    n = 0;
    hs = 1'b1;
    repeat (2) @(negedge mclk_i);
    hs = 1'b0;
    for (int j = 0; j < 38; j++)
    begin
      ext = j >= 8 && j < 13;
      @(negedge mclk_i);
      n += av;
    end
    chk(8'(n), 8'(exp));
  endtask
  task automatic frame(input logic [7:0] opt);
    int vst;
    fld = !fld;
    vs = 1'b1;
    repeat (2) @(negedge mclk_i);
    vs = 1'b0;
    repeat (4) @(negedge mclk_i);
    vst = 2 + (fld ? opt[2:0] : 0);
    for (int k = 1; k < 5; k++)
      line(!opt[3] ? 5 : k >= vst && k < vst + 2 ? 6 : 0);
  endtask

  always @(negedge mclk_i)
    pix_i <= 8'($urandom);
  always @(negedge mclk_i)
  begin
    hist <= {hist[23:0], pix_o};
    av_d <= av;
    if (emb && av && !av_d)
      chk(hist[31:8] == 24'hff_0000 ? hist[7:0] : 8'h00, xy(fld, 1'b0, 1'b0));
  end

  initial
  begin
    #600_000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    {pin, idle, hs, vs, ext, emb, fld} = 7'h0;
    void'($urandom(63231));
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    host_model_i.rd(8'h26, 9);
    for (int k = 0; k < 9; k++)
      chk(host_model_i.rb[k], rst_tab[k]);
    chk({7'h0, sdo}, 8'h00);
    host_model_i.wr(7'h4d, 8'h27, 8'h00, ok);
    chk({7'h0, ok}, 8'h00);
    repeat (4)
    begin
      d = 8'($urandom);
      idle = !idle;
      host_model_i.wr(7'h4c, 8'h27, d, ok);
      repeat (6) @(negedge mclk_i);
      chk({5'h0, lp, a0, mck}, {5'h0, d[7] & idle, d[6], d[5]});
      host_model_i.rd(8'h27, 1);
      chk(host_model_i.rb[0], d);
      chk({7'h0, ok}, 8'h01);
    end
    for (int f = 0; f < 4; f++)
      for (int m = 0; m < 3; m++)
      begin
        pin = m != 0;
        host_model_i.wr(7'h4c, 8'h26, {4'h0, m < 2, f[1:0], m == 0}, ok);
        repeat (6) @(negedge mclk_i);
        chk({5'h0, pd, sgt, otri}, pwr(f[1:0], m < 2));
      end
    for (int k = 0; k < 6; k++)
      host_model_i.wr(7'h4c, 8'h28 + 8'(k), v_tab[k], ok);
    foreach (opt_tab[c])
    begin
      host_model_i.wr(7'h4c, 8'h27, opt_tab[c], ok);
      emb = opt_tab[c][4];
      repeat (2) frame(opt_tab[c]);
    end
    end_of_test();
  end
endmodule
